// File: logic/repeater_port_role_test_regs.sv
// register bank for port role, forced high-speed test mode and phy tuning
`timescale 1ns/100ps
module repeater_port_role_test_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire role_test_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire logic host_mode_enable,
	input wire logic peripheral_mode_enable,
	input wire logic charging_port_secondary_detect_enable,
	input wire logic primary_detect_event,
	output logic forced_highspeed_active,
	output logic [7:0] tx_swing,
	output logic [7:0] tx_preemphasis,
	output logic [7:0] rx_equalization,
	output logic [7:0] disconnect_squelch
);
	import role_test_pkg::*;

	bank_state_t st;
	bank_state_t next_st;

	// next state: soft reset acts like hard reset on every field
	always_comb begin
		next_st = st;
		if (soft_reset) begin
			next_st = '0;
			next_st.test_ctl = test_control_reset;
		end else begin
			// first enable after reset decides the role, later ones ignored
			if (st.role == role_none) begin
				if (host_mode_enable)
					next_st.role = role_host;
				else if (peripheral_mode_enable)
					next_st.role = role_device;
			end
			if (charging_port_secondary_detect_enable && primary_detect_event)
				next_st.primary_seen = 1'b1;
			if (req.wr) begin
				case (req.addr)
					tx_swing_tuning_off: next_st.tx_swing = req.wdata;
					tx_preemphasis_tuning_off: next_st.tx_pre = req.wdata;
					rx_equalization_tuning_off: next_st.rx_eq = req.wdata;
					disconnect_squelch_threshold_off: next_st.disc_sq = req.wdata;
					test_control_off: next_st.test_ctl = req.wdata;
					default: ;
				endcase
			end
			// sticky: writing zero cannot leave the forced state
			if (next_st.test_ctl[force_bit])
				next_st.forced_hs = 1'b1;
			if (req.rd) begin
				case (req.addr)
					port_role_status_off: begin
						next_st.rdata = '0;
						next_st.rdata[role_lsb +: 2] = st.role;
						// inverted sense: zero means detection was seen or detection is disabled
						next_st.rdata[detect_bit] = charging_port_secondary_detect_enable
							& ~st.primary_seen;
					end
					tx_swing_tuning_off: next_st.rdata = st.tx_swing;
					tx_preemphasis_tuning_off: next_st.rdata = st.tx_pre;
					rx_equalization_tuning_off: next_st.rdata = st.rx_eq;
					disconnect_squelch_threshold_off: next_st.rdata = st.disc_sq;
					test_control_off: next_st.rdata = st.test_ctl;
					default: next_st.rdata = '0;
				endcase
			end
		end
	end

	// state register, constants only under reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{test_ctl: test_control_reset, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// outputs come straight from the state flops, no logic after them
	assign rdata = st.rdata;
	assign forced_highspeed_active = st.forced_hs;
	assign tx_swing = st.tx_swing;
	assign tx_preemphasis = st.tx_pre;
	assign rx_equalization = st.rx_eq;
	assign disconnect_squelch = st.disc_sq;

	// forced state, role, detection read and test write: the checks below watch the state flops directly,
	// so a slip in the next-state logic shows up one edge after it happens
	force_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.forced_hs && !soft_reset |=> st.forced_hs)
		else $error("forced high-speed state released without reset");
	force_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == test_control_off && req.wdata[force_bit] && !soft_reset |=> st.forced_hs)
		else $error("force bit write did not enter forced state");
	role_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.role != role_none && !soft_reset |=> $stable(st.role))
		else $error("role changed after being chosen");
	role_none_a: assert property (@(posedge mclk) disable iff (!rst_n)
		soft_reset |=> st.role == role_none && !st.forced_hs)
		else $error("soft reset did not clear role");
	role_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == port_role_status_off && !soft_reset |=> rdata[4:3] == $past(st.role) && rdata[7:5] == 3'h0)
		else $error("role field read back wrong");
	detect_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == port_role_status_off && !soft_reset && charging_port_secondary_detect_enable
		&& st.primary_seen |=> rdata[0] == 1'b0)
		else $error("primary detection not reported");
	host_pick_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.role == role_none && host_mode_enable && !soft_reset |=> st.role == role_host)
		else $error("host enable did not select host role");
	test_rw_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == test_control_off && !soft_reset |=> st.test_ctl == $past(req.wdata))
		else $error("test register lost written value");

	// test register: software reads the reserved bits back before rewriting them
	test_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == test_control_off && !soft_reset |=> rdata == $past(st.test_ctl))
		else $error("test register read back wrong");
	force_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!st.forced_hs && !(req.wr && req.addr == test_control_off && req.wdata[force_bit])
		|=> !st.forced_hs)
		else $error("forced state entered without a force write");
	force_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
		soft_reset |=> !forced_highspeed_active && st.test_ctl == test_control_reset)
		else $error("soft reset did not restore the test register");

	// role selection: host wins a tie, and no role appears without an enable;
	// the reserved code must never be reachable from any input sequence
	periph_pick_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.role == role_none && !host_mode_enable && peripheral_mode_enable && !soft_reset
		|=> st.role == role_device)
		else $error("peripheral enable did not select device role");
	host_tie_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.role == role_none && host_mode_enable && peripheral_mode_enable && !soft_reset
		|=> st.role == role_host)
		else $error("host enable lost a tie with peripheral enable");
	role_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.role == role_none && !host_mode_enable && !peripheral_mode_enable |=> st.role == role_none)
		else $error("role chosen without an enable");
	role_code_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.role != 2'h3)
		else $error("reserved role code reached");
	role_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == port_role_status_off && !host_mode_enable && !peripheral_mode_enable
		&& !soft_reset |=> $stable(st.role))
		else $error("write changed the read only role field");
	role_spare_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == port_role_status_off && !soft_reset |=> rdata[2:1] == 2'h0)
		else $error("reserved bits of role status not zero");

	// detection flag: latched only while the enable is high, sticky until a reset
	detect_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		charging_port_secondary_detect_enable && primary_detect_event && !soft_reset |=> st.primary_seen)
		else $error("primary detection with enable not latched");
	detect_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!st.primary_seen && !(charging_port_secondary_detect_enable && primary_detect_event)
		|=> !st.primary_seen)
		else $error("primary detection latched without enable and event");
	detect_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st.primary_seen && !soft_reset |=> st.primary_seen)
		else $error("primary detection flag lost without reset");
	detect_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		soft_reset |=> !st.primary_seen)
		else $error("soft reset left the detection flag set");
	detect_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == port_role_status_off && !soft_reset && charging_port_secondary_detect_enable
		&& !st.primary_seen |=> rdata[0] == 1'b1)
		else $error("detection reported before it was seen");
	detect_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == port_role_status_off && !soft_reset && !charging_port_secondary_detect_enable
		|=> rdata[0] == 1'b0)
		else $error("detection bit set while detection is disabled");

	// tuning registers hold exactly what software last wrote, so a platform can
	// refine the starting values freely; nothing but a write or a reset moves them
	swing_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == tx_swing_tuning_off && !soft_reset |=> tx_swing == $past(req.wdata))
		else $error("swing tuning lost written value");
	pre_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == tx_preemphasis_tuning_off && !soft_reset |=> tx_preemphasis == $past(req.wdata))
		else $error("pre-emphasis tuning lost written value");
	eq_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == rx_equalization_tuning_off && !soft_reset |=> rx_equalization == $past(req.wdata))
		else $error("equalization tuning lost written value");
	squelch_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr && req.addr == disconnect_squelch_threshold_off && !soft_reset
		|=> disconnect_squelch == $past(req.wdata))
		else $error("threshold tuning lost written value");
	tune_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!req.wr && !soft_reset |=> $stable(tx_swing) && $stable(tx_preemphasis) && $stable(rx_equalization)
		&& $stable(disconnect_squelch))
		else $error("tuning value changed without a write");
	tune_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		soft_reset |=> tx_swing == tuning_reset && tx_preemphasis == tuning_reset
		&& rx_equalization == tuning_reset && disconnect_squelch == tuning_reset && rdata == 8'h00)
		else $error("soft reset did not clear tuning and read data");

	// read path: each tuning and test register reads back its own flops, unmapped offsets read zero
	swing_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == tx_swing_tuning_off && !soft_reset |=> rdata == $past(tx_swing))
		else $error("swing tuning read back wrong");
	pre_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == tx_preemphasis_tuning_off && !soft_reset |=> rdata == $past(tx_preemphasis))
		else $error("pre-emphasis tuning read back wrong");
	eq_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == rx_equalization_tuning_off && !soft_reset |=> rdata == $past(rx_equalization))
		else $error("equalization tuning read back wrong");
	squelch_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && req.addr == disconnect_squelch_threshold_off && !soft_reset
		|=> rdata == $past(disconnect_squelch))
		else $error("threshold tuning read back wrong");
	unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		req.rd && !soft_reset && req.addr != port_role_status_off && req.addr != tx_swing_tuning_off
		&& req.addr != tx_preemphasis_tuning_off && req.addr != rx_equalization_tuning_off
		&& req.addr != disconnect_squelch_threshold_off && req.addr != test_control_off |=> rdata == 8'h00)
		else $error("unmapped offset read back non-zero");
	rdata_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!req.rd && !soft_reset |=> $stable(rdata))
		else $error("read data changed without a read");
endmodule : repeater_port_role_test_regs

// File: logic/role_test_pkg.sv
// constants and carrier types for the port role and test register bank
package role_test_pkg;
	localparam logic [7:0] port_role_status_off = 8'h60;
	localparam logic [7:0] tx_swing_tuning_off = 8'h70;
	localparam logic [7:0] tx_preemphasis_tuning_off = 8'h71;
	localparam logic [7:0] rx_equalization_tuning_off = 8'h72;
	localparam logic [7:0] disconnect_squelch_threshold_off = 8'h73;
	localparam logic [7:0] test_control_off = 8'hF5;
	localparam logic [7:0] test_control_reset = 8'h32;
	localparam logic [7:0] tuning_reset = 8'h00;
	localparam int role_lsb = 3;
	localparam int force_bit = 3;
	localparam int detect_bit = 0;
	localparam logic [1:0] role_none = 2'h0;
	localparam logic [1:0] role_host = 2'h1;
	localparam logic [1:0] role_device = 2'h2;

	// register access request from the serial management front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// whole state of the bank
	typedef struct packed {
		logic [1:0] role;
		logic primary_seen;
		logic forced_hs;
		logic [7:0] test_ctl;
		logic [7:0] tx_swing;
		logic [7:0] tx_pre;
		logic [7:0] rx_eq;
		logic [7:0] disc_sq;
		logic [7:0] rdata;
	} bank_state_t;
endpackage : role_test_pkg

// File: tb/soc_role_model.sv
// soc side model that selects the repeater role
`timescale 1ns/100ps
module soc_role_model (
	input wire logic mclk,
	input wire logic [1:0] pick,
	output logic host_en,
	output logic periph_en
);
	// only the soc picks the role, the repeater keeps the first one it is given
	always @(negedge mclk) begin
		host_en <= pick == 2'h1;
		periph_en <= pick == 2'h2;
	end
endmodule : soc_role_model

// File: tb/tb_repeater_port_role_test_regs.sv
// bench for the port role, test mode and tuning register bank
`timescale 1ns/100ps
module tb_repeater_port_role_test_regs;
	import role_test_pkg::*;
	logic mclk, rst_n, soft_reset, det_en, ev, host_en, periph_en, forced;
	logic [1:0] pick;
	logic [7:0] rdata, tx_sw, tx_pe, rx_eq, disc;
	reg_req_t req;
	int fail_count, checks_done;
	// rows of offset, write data, expected read back
	localparam logic [23:0] rows [7] = '{24'h707C7C, 24'h713C3C, 24'h729292, 24'h738383,
		24'h707979, 24'h713939, 24'h105500};
	soc_role_model soc_role_model_i (.mclk(mclk), .pick(pick), .host_en(host_en), .periph_en(periph_en));
	repeater_port_role_test_regs repeater_port_role_test_regs_i (.mclk(mclk), .rst_n(rst_n),
		.soft_reset(soft_reset), .req(req), .rdata(rdata), .host_mode_enable(host_en),
		.peripheral_mode_enable(periph_en), .charging_port_secondary_detect_enable(det_en),
		.primary_detect_event(ev), .forced_highspeed_active(forced), .tx_swing(tx_sw),
		.tx_preemphasis(tx_pe), .rx_equalization(rx_eq), .disconnect_squelch(disc));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk) req = '{1'b1, 1'b0, a, d};
		@(negedge mclk) req.wr = 1'b0;
	endtask : wr
	// read data lands half a cycle after the strobe, looked at a half cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk) req.rd = 1'b0;
		chk("rdata", rdata, e);
	endtask : rd
	task results;
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// run needs far under this span, so reaching it means a hang
	initial begin
		#50000;
		fail_count++;
		results();
	end
	initial begin
		{rst_n, soft_reset, det_en, ev, pick} = '0;
		req = '0;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		rd(8'h60, 8'h00);
		wr(8'h60, 8'h18);
		rd(8'h60, 8'h00);
		rd(8'hF5, 8'h32);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
			if (i == 3) chk("tx_preemphasis", tx_pe, 8'h3C);
		end
		chk("tx_swing", tx_sw, 8'h79);
		chk("tx_preemphasis", tx_pe, 8'h39);
		chk("rx_equalization", rx_eq, 8'h92);
		chk("disconnect_squelch", disc, 8'h83);
		@(negedge mclk) pick = 2'h1;
		repeat (2) @(negedge mclk);
		pick = 2'h2;
		rd(8'h60, 8'h08);
		wr(8'h60, 8'hFF);
		rd(8'h60, 8'h08);
		// an event while detection is disabled must not latch
		@(negedge mclk) ev = 1'b1;
		@(negedge mclk) ev = 1'b0;
		det_en = 1'b1;
		rd(8'h60, 8'h09);
		@(negedge mclk) ev = 1'b1;
		@(negedge mclk) ev = 1'b0;
		rd(8'h60, 8'h08);
		wr(8'hF5, 8'h3A);
		chk("forced", {7'h00, forced}, 8'h01);
		wr(8'hF5, 8'h32);
		rd(8'hF5, 8'h32);
		chk("forced", {7'h00, forced}, 8'h01);
		det_en = 1'b0;
		@(negedge mclk) soft_reset = 1'b1;
		@(negedge mclk) soft_reset = 1'b0;
		chk("forced", {7'h00, forced}, 8'h00);
		chk("tx_swing", tx_sw, 8'h00);
		chk("disconnect_squelch", disc, 8'h00);
		rd(8'h60, 8'h10);
		rd(8'hF5, 8'h32);
		// a hard reset in mid-run must also leave the forced state
		wr(8'h70, 8'h7C);
		wr(8'hF5, 8'h3A);
		@(negedge mclk) rst_n = 1'b0;
		@(negedge mclk) chk("forced", {7'h00, forced}, 8'h00);
		chk("tx_swing", tx_sw, 8'h00);
		rst_n = 1'b1;
		rd(8'hF5, 8'h32);
		rd(8'h60, 8'h10);
		results();
	end
endmodule : tb_repeater_port_role_test_regs
